/* inc/eba_pkg.sv */
package eba_pkg;
   localparam int EBA_SYNC_STAGES = 2;
   localparam int EBA_RELEASE_DRIVE_CYCLES = 1;
   localparam logic EBA_LINE_ASSERTED = 1'b0;
   localparam logic EBA_LINE_IDLE = 1'b1;
   typedef enum logic [1:0] {
      EBA_SLAVE = 2'b00,
      EBA_PENDING = 2'b01,
      EBA_MASTER = 2'b10,
      EBA_RELEASE = 2'b11
   } eba_state_e;
endpackage

/* inc/eba_sync_if.sv */
`timescale 1ns/1ps
interface eba_sync_if;
   logic grant_raw_n;
   logic busy_raw_n;
   logic grant_n;
   logic busy_n;
   modport sync (input grant_raw_n, input busy_raw_n, output grant_n, output busy_n);
   modport core (output grant_raw_n, output busy_raw_n, input grant_n, input busy_n);
endinterface

/* rtl/eba_sync.sv */
`timescale 1ns/1ps
module eba_sync
   import eba_pkg::*;
#(
   parameter int STAGES = EBA_SYNC_STAGES
) (
   input wire logic clk,
   input wire logic rst_sync_n,
   input wire logic sync_en,
   eba_sync_if.sync sif
);
   logic [STAGES-1:0] grant_q, grant_d;
   logic [STAGES-1:0] busy_q, busy_d;
   always_comb begin
      grant_d = {grant_q[STAGES-2:0], sif.grant_raw_n};
      busy_d = {busy_q[STAGES-2:0], sif.busy_raw_n};
   end
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         grant_q <= '1;
         busy_q <= '1;
      end else begin
         grant_q <= grant_d;
         busy_q <= busy_d;
      end
   end
   // bypass trades safety for latency; only valid with a synchronous arbiter
   assign sif.grant_n = sync_en ? grant_q[STAGES-1] : sif.grant_raw_n;
   assign sif.busy_n = sync_en ? busy_q[STAGES-1] : sif.busy_raw_n;
endmodule

/* rtl/eba_arbiter.sv */
`timescale 1ns/1ps
module eba_arbiter
   import eba_pkg::*;
#(
   parameter int RELEASE_CYCLES = EBA_RELEASE_DRIVE_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ext_access_req,
   input wire logic int_access_req,
   input wire logic cycle_end,
   input wire logic request_hold_bit,
   input wire logic stop_wait,
   input wire logic async_arbitration_enable,
   input wire logic mastership_drive_enable,
   input wire logic cas_strobe,
   output logic bus_request_line_n,
   input wire logic bus_grant_line_n,
   input wire logic bus_busy_line_n_i,
   output logic bus_busy_line_n_o,
   output logic bus_busy_line_n_oe,
   output logic cas_n_o,
   output logic cas_n_oe,
   output logic is_master
);
   logic rst_meta_q, rst_sync_n;
   eba_state_e state_q, state_d;
   logic req_q, req_d;
   logic [7:0] rel_cnt_q, rel_cnt_d;
   logic grant, busy_idle;
   eba_sync_if sif();

   // reset released through two flops; the first flop feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_n <= rst_meta_q;
      end
   end

   assign sif.grant_raw_n = bus_grant_line_n;
   assign sif.busy_raw_n = bus_busy_line_n_i;
   eba_sync u_sync (
      .clk(clk),
      .rst_sync_n(rst_sync_n),
      .sync_en(async_arbitration_enable),
      .sif(sif)
   );
   assign grant = (sif.grant_n == EBA_LINE_ASSERTED);
   assign busy_idle = (sif.busy_n == EBA_LINE_IDLE);

   always_comb begin
      req_d = req_q;
      if (stop_wait) begin
         if (!request_hold_bit) begin
            req_d = 1'b0;
         end
      end else begin
         // internal accesses are deliberately not looked at
         req_d = ext_access_req | request_hold_bit;
      end
   end

   always_comb begin
      state_d = state_q;
      rel_cnt_d = rel_cnt_q;
      case (state_q)
         EBA_SLAVE: begin
            if (grant) begin
               state_d = EBA_PENDING;
            end
         end
         EBA_PENDING: begin
            if (!grant) begin
               state_d = EBA_SLAVE;
            end else if (busy_idle) begin
               state_d = EBA_MASTER;
            end
         end
         EBA_MASTER: begin
            // stays here while granted even with no request: parking
            if (!grant && (cycle_end || !ext_access_req)) begin
               state_d = EBA_RELEASE;
               rel_cnt_d = 8'(RELEASE_CYCLES - 1);
            end
         end
         EBA_RELEASE: begin
            if (rel_cnt_q == 8'h00) begin
               state_d = EBA_SLAVE;
            end else begin
               rel_cnt_d = rel_cnt_q - 8'h01;
            end
         end
         default: state_d = EBA_SLAVE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state_q <= EBA_SLAVE;
         req_q <= 1'b0;
         rel_cnt_q <= 8'h00;
      end else begin
         state_q <= state_d;
         req_q <= req_d;
         rel_cnt_q <= rel_cnt_d;
      end
   end

   assign bus_request_line_n = ~req_q;
   assign is_master = (state_q == EBA_MASTER);
   // busy driven low while master, driven high briefly on release, else floated
   assign bus_busy_line_n_oe = (state_q == EBA_MASTER) || (state_q == EBA_RELEASE);
   assign bus_busy_line_n_o = (state_q == EBA_MASTER) ? EBA_LINE_ASSERTED : EBA_LINE_IDLE;
   assign cas_n_oe = is_master | mastership_drive_enable;
   assign cas_n_o = is_master ? ~cas_strobe : EBA_LINE_IDLE;

   a_reset_slave: assert property (@(posedge clk)
      $rose(rst_sync_n)
      |-> state_q == EBA_SLAVE && req_q == 1'b0)
      else $error("not slave after reset");

   // the request is registered, so request checks look one edge after the inputs
   a_request_on_need: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (!stop_wait && ext_access_req)
      |=> !bus_request_line_n)
      else $error("request missing while bus needed");
   a_request_external: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (!stop_wait && !request_hold_bit)
      |=> bus_request_line_n == ~$past(ext_access_req))
      else $error("request not from external access");
   a_internal_ignored: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (!stop_wait && !request_hold_bit && !ext_access_req && int_access_req)
      |=> bus_request_line_n)
      else $error("internal access raised request");
   a_hold_request: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (!stop_wait && request_hold_bit)
      |=> !bus_request_line_n)
      else $error("hold bit did not keep request");
   a_hold_in_stop: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (stop_wait && request_hold_bit)
      |=> $stable(bus_request_line_n))
      else $error("request changed in stop with hold");
   a_drop_in_stop: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (stop_wait && !request_hold_bit)
      |=> bus_request_line_n)
      else $error("request not dropped in stop");

   a_grant_to_pending: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (state_q == EBA_SLAVE && grant)
      |=> state_q == EBA_PENDING)
      else $error("grant not taken as nomination");
   sequence s_pending_blocked;
      state_q == EBA_PENDING && grant && !busy_idle;
   endsequence
   sequence s_take_over;
      state_q == EBA_PENDING && grant && busy_idle;
   endsequence
   a_pending_waits: assert property (@(posedge clk) disable iff (!rst_sync_n)
      s_pending_blocked
      |=> state_q == EBA_PENDING)
      else $error("left pending while bus busy");
   a_master_needs_idle: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (state_q == EBA_PENDING && state_d == EBA_MASTER)
      |-> busy_idle && grant)
      else $error("took bus while busy");
   a_take_over: assert property (@(posedge clk) disable iff (!rst_sync_n)
      s_take_over
      |=> is_master && bus_busy_line_n_oe && !bus_busy_line_n_o)
      else $error("idle bus not taken over");
   a_busy_master: assert property (@(posedge clk) disable iff (!rst_sync_n)
      is_master
      |-> bus_busy_line_n_oe && !bus_busy_line_n_o)
      else $error("master not asserting busy");
   a_sync_delay: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (async_arbitration_enable && $past(rst_sync_n) && $past(rst_sync_n, 2))
      |-> sif.grant_n == $past(bus_grant_line_n, 2) && sif.busy_n == $past(bus_busy_line_n_i, 2))
      else $error("grant or busy not synchronised");

   a_park_granted: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (is_master && grant)
      |=> is_master)
      else $error("parked master lost bus while granted");
   a_stay_mid_cycle: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (is_master && !cycle_end && ext_access_req)
      |=> is_master)
      else $error("bus given up inside a cycle");
   a_leave_at_end: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (is_master && !grant && cycle_end)
      |=> state_q == EBA_RELEASE)
      else $error("bus kept after grant loss");
   sequence s_release_start;
      state_q == EBA_MASTER && state_d == EBA_RELEASE;
   endsequence
   sequence s_release_drive;
      bus_busy_line_n_oe && bus_busy_line_n_o ##1 !bus_busy_line_n_oe;
   endsequence
   a_busy_release: assert property (@(posedge clk) disable iff (!rst_sync_n)
      s_release_start
      |=> s_release_drive)
      else $error("busy not released by active pull-up");
   a_slave_floats_busy: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (state_q == EBA_SLAVE || state_q == EBA_PENDING)
      |-> !bus_busy_line_n_oe)
      else $error("busy driven while not master");

   a_cas_float: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (!is_master && !mastership_drive_enable)
      |-> !cas_n_oe)
      else $error("column strobe driven while slave");
   a_cas_master: assert property (@(posedge clk) disable iff (!rst_sync_n)
      is_master
      |-> cas_n_oe && cas_n_o == ~cas_strobe)
      else $error("column strobe not driven by master");
endmodule

/* verif/eba_far_side.sv */
`timescale 1ns/1ps
module eba_far_side #(
   parameter int GAP = 3
) (
   input wire logic clk,
   input wire logic give_grant,
   input wire logic other_hold,
   input wire logic bus_busy_line_n_o,
   input wire logic bus_busy_line_n_oe,
   output logic bus_grant_line_n,
   output logic busy_wire_n
);
   logic gnt_q = 1'b0;
   int gap_q = 0;
   // only the device is ever granted here; others just hold busy
   assign bus_grant_line_n = !(give_grant && (gnt_q || gap_q == 0));
   // pull-up wins unless someone drives low
   assign busy_wire_n = !((bus_busy_line_n_oe && !bus_busy_line_n_o) || other_hold);
   always @(posedge clk) begin
      gnt_q <= !bus_grant_line_n;
      if (gnt_q && bus_grant_line_n) gap_q <= GAP;
      else if (gap_q > 0) gap_q <= gap_q - 1;
   end
endmodule

/* verif/eba_arbiter_test.sv */
`timescale 1ns/1ps
module eba_arbiter_test;
   import eba_pkg::*;
   logic clk = 0, rst_n = 0, ext = 0, intr = 0, cend = 0, hold = 0, sw = 0;
   logic sync = 0, mde = 0, cas = 0, gg = 0, oh = 0;
   logic req_n, gnt_n, busy_n, b_o, b_oe, cas_o, cas_oe, mst;
   int failures = 0, total_checks = 0;
   logic [31:0] seed = 32'hcb44da62;
   always #5 clk = ~clk;
   eba_arbiter eba_arbiter_i (.clk(clk), .rst_n(rst_n), .ext_access_req(ext), .int_access_req(intr),
      .cycle_end(cend), .request_hold_bit(hold), .stop_wait(sw), .async_arbitration_enable(sync),
      .mastership_drive_enable(mde), .cas_strobe(cas), .bus_request_line_n(req_n),
      .bus_grant_line_n(gnt_n), .bus_busy_line_n_i(busy_n), .bus_busy_line_n_o(b_o),
      .bus_busy_line_n_oe(b_oe), .cas_n_o(cas_o), .cas_n_oe(cas_oe), .is_master(mst));
   eba_far_side eba_far_side_i (.clk(clk), .give_grant(gg), .other_hold(oh), .bus_busy_line_n_o(b_o),
      .bus_busy_line_n_oe(b_oe), .bus_grant_line_n(gnt_n), .busy_wire_n(busy_n));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // in stop/wait the hold bit freezes the last request
   function automatic logic exp_req_n(logic e, logic h, logic s, logic last_n);
      if (s) return h ? last_n : 1'b1;
      return !(e | h);
   endfunction
   task automatic chk(string what, logic exp, logic got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic tally_and_finish();
      if (failures == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      #100000;
      failures++;
      tally_and_finish();
   end
   initial begin
      logic last_n;
      logic [31:0] r;
      repeat (5) @(negedge clk);
      chk("req_reset", 1'b1, req_n);
      chk("oe_reset", 1'b0, b_oe);
      rst_n = 1;
      repeat (3) @(negedge clk);
      chk("slave_reset", 1'b0, mst);
      for (int i = 0; i < 300; i++) begin
         last_n = req_n;
         r = rnd();
         {ext, intr, hold} = r[2:0];
         sw = r[3] & r[4];
         @(negedge clk);
         chk("request", exp_req_n(ext, hold, sw, last_n), req_n);
      end
      {ext, intr, hold, sw} = 4'b1000;
      for (int s = 0; s < 2; s++) begin
         sync = s[0];
         mde = 0;
         oh = 1;
         gg = 1;
         cas = 1;
         repeat (6) @(negedge clk);
         chk("wait_busy", 1'b0, mst);
         chk("no_drive", 1'b0, b_oe);
         chk("cas_float", 1'b0, cas_oe);
         oh = 0;
         repeat (4) @(negedge clk);
         chk("master", 1'b1, mst);
         chk("busy_low", 1'b0, busy_n);
         chk("cas_oe", 1'b1, cas_oe);
         chk("cas_low", 1'b0, cas_o);
         ext = 0;
         cas = 0;
         repeat (3) @(negedge clk);
         chk("park", 1'b1, mst);
         chk("req_drop", 1'b1, req_n);
         chk("cas_high", 1'b1, cas_o);
         ext = 1;
         gg = 0;
         repeat (4) @(negedge clk);
         chk("mid_cycle", 1'b1, mst);
         cend = 1;
         @(negedge clk);
         cend = 0;
         chk("high_oe", 1'b1, b_oe);
         chk("high_val", 1'b1, b_o);
         @(negedge clk);
         chk("float", 1'b0, b_oe);
         chk("slave", 1'b0, mst);
         chk("pull_up", 1'b1, busy_n);
      end
      mde = 1;
      @(negedge clk);
      chk("cas_kept", 1'b1, cas_oe);
      rst_n = 0;
      #1;
      chk("req_async", 1'b1, req_n);
      tally_and_finish();
   end
endmodule
